// ---- logic/overcurrent_stage_indication.sv ----
// Two-stage overcurrent start/trip, indication and settings logic
// Operation
// - Each stage: yellow when started, red when tripped
// - Four indications each self-reset or manual-reset
// - Manual indication stays lit until explicit reset
// - Reset button or serial command clears manual
// - Indicator state never affects protection
// - Blank display: trip lights faulted phase indicators
// - Step or reset button clears phase indication
// - Permanent fault lights alarm and drives relay
// - Fault code shown on display
// - Low start current clamped to its range
// - Definite time: three operate time ranges
// - Inverse time uses time multiplier instead
// - High start range set by range switch
// - Infinite high setting disables high stage
// - High operate time in three switch ranges
// - Switchgroup checksum shown when selected
// - Separate block input inhibits each stage trip
// - Two start outputs for auto-reclose
// - Setting shown with its knob indicator lit
// - Start over threshold, trip after delay
// - Latching switch holds trips until reset
`timescale 1ns/10ps
`include "oc_stage_defines.svh"

module overcurrent_stage_indication #(
    parameter int unsigned TICK_CYCLES = (`CLK_HZ / 1000) * `TICK_MS,
    parameter int unsigned ALARM_CYCLES = (`CLK_HZ / 1000000) * `ALARM_US
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // Measurement
    input wire logic meas_valid_in,
    input wire oc_stage_pkg::phase_currents_t currents_in,
    // External blocking
    input wire logic ext_block_in_a,
    input wire logic ext_block_in_b,
    input wire logic ext_block_in_c,
    // Front panel
    input wire logic step_btn_in,
    input wire logic reset_btn_in,
    input wire logic display_blank_in,
    input wire logic [2:0] display_sel_in,
    // Self-supervision
    input wire logic internal_fault_in,
    input wire logic [11:0] fault_code_in,
    // Stage signals
    output logic low_stage_start_out,
    output logic low_stage_trip_out,
    output logic high_stage_start_out,
    output logic high_stage_trip_out,
    output logic reclose_start_a_out,
    output logic reclose_start_b_out,
    // Indication
    output oc_stage_pkg::two_colour_t low_indicator_out,
    output oc_stage_pkg::two_colour_t high_indicator_out,
    output logic [2:0] phase_fault_out,
    output logic self_supervision_alarm_out,
    output logic supervision_relay_out,
    output logic [15:0] display_value_out,
    output logic display_fault_out,
    output logic [5:0] knob_led_out
);
    import oc_stage_pkg::*;

    if (TICK_CYCLES < 1 || ALARM_CYCLES < 1)
    begin : g_param_check
        $error("TICK_CYCLES and ALARM_CYCLES must be at least 1");
    end

    function automatic logic [15:0] clamp(input logic [15:0] v,
        input logic [15:0] lo, input logic [15:0] hi);
        if (v < lo)
            return lo;
        if (v > hi)
            return hi;
        return v;
    endfunction : clamp

    function automatic logic [16:0] delay_ticks(input logic [15:0] v,
        input logic [15:0] lo, input logic [1:0] range);
        logic [16:0] base;
        base = {1'b0, clamp(v, lo, `TIME_MAX)};
        case (range)
            2'b00: return base;
            2'b11: return 17'(base * 17'd100);
            default: return 17'(base * 17'd10);
        endcase
    endfunction : delay_ticks

    // Registers written by software
    logic [15:0] switch_q;
    logic [15:0] low_set_q, low_time_q, low_k_q, high_time_q;
    logic [16:0] high_set_q;
    logic cmd_a_q, cmd_b_q;
    // Bus state
    logic [7:0] addr_q;
    logic wr_pend_q;
    logic [31:0] rdata_q;
    // Protection state, index 0 low stage, 1 high stage
    logic [2:0] over_q [2];
    logic [16:0] cnt_q [2];
    logic [1:0] trip_q;
    logic [1:0] start_mem_q, trip_mem_q;
    logic [2:0] pf_q;
    logic [31:0] tick_cnt_q, alarm_cnt_q;
    logic tick;
    logic alarm_q;
    logic [11:0] code_q;
    logic [15:0] disp_q;
    logic [5:0] led_q;

    logic [7:0] sg;
    logic [3:0] ind_mode, route;
    logic [15:0] thr [2];
    logic [16:0] target [2];
    logic high_inf;
    logic [1:0] start, block, trip_cond, start_show, trip_show;
    logic ind_clr, latch_clr, pf_clr;
    logic [2:0] pf_set;
    logic addr_ph;
    logic [31:0] rmux;

    assign sg = switch_q[7:0];
    assign ind_mode = switch_q[11:8];
    assign route = switch_q[15:12];
    assign high_inf = high_set_q[`HIGH_INF_BIT];

    assign thr[0] = clamp(low_set_q, `LOW_THR_MIN, `LOW_THR_MAX);
    assign thr[1] = sg[`SW_HRANGE_BIT] ?
        clamp(high_set_q[15:0], `HIGH_THR_MIN_B, `HIGH_THR_MAX_B) :
        clamp(high_set_q[15:0], `HIGH_THR_MIN_A, `HIGH_THR_MAX_A);

    assign target[0] = sg[`SW_CHAR_BIT] ?
        17'(clamp(low_k_q, `LOW_TIME_MIN, `TIME_MAX) * `INV_TIME_SCALE) :
        delay_ticks(low_time_q, `LOW_TIME_MIN, sg[1:0]);
    assign target[1] = delay_ticks(high_time_q, `HIGH_TIME_MIN,
        sg[7:6]);

    assign block[0] = (ext_block_in_a & route[0]) |
        (ext_block_in_c & route[2]);
    assign block[1] = (ext_block_in_b & route[1]) |
        (ext_block_in_c & route[3]);

    // Indicator state is not read here: protection is independent
    always_comb
    begin
        for (int s = 0; s < 2; s++)
        begin
            start[s] = |over_q[s] && !(s == 1 && high_inf);
            trip_cond[s] = start[s] && cnt_q[s] >= target[s] &&
                !block[s];
        end
    end

    assign ind_clr = reset_btn_in | cmd_a_q | cmd_b_q;
    assign latch_clr = (step_btn_in & reset_btn_in) | cmd_a_q;
    assign pf_clr = step_btn_in | reset_btn_in;

    // Time base of 10 ms ticks
    assign tick = tick_cnt_q == TICK_CYCLES - 1;
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            tick_cnt_q <= 32'h0;
        else
            tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
    end

    // Per-phase comparison on each measurement update
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            over_q[0] <= 3'h0;
            over_q[1] <= 3'h0;
        end
        else if (meas_valid_in)
        begin
            for (int s = 0; s < 2; s++)
                over_q[s] <= {currents_in.l3 > thr[s],
                    currents_in.l2 > thr[s],
                    currents_in.l1 > thr[s]};
            if (high_inf)
                over_q[1] <= 3'h0;
        end
    end

    // Operate delay counters and trip outputs
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            cnt_q[0] <= 17'h0;
            cnt_q[1] <= 17'h0;
            trip_q <= 2'b00;
        end
        else
        begin
            for (int s = 0; s < 2; s++)
            begin
                if (!start[s])
                    cnt_q[s] <= 17'h0;
                else if (tick && cnt_q[s] < target[s])
                    cnt_q[s] <= cnt_q[s] + 17'h1;
                trip_q[s] <= trip_cond[s] | (sg[`SW_LATCH_BIT] &
                    trip_q[s] & !latch_clr &
                    !(s == 1 && high_inf));
            end
        end
    end

    // Manual-reset memories; a new event wins over a clear
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            start_mem_q <= 2'b00;
            trip_mem_q <= 2'b00;
        end
        else
        begin
            for (int s = 0; s < 2; s++)
            begin
                start_mem_q[s] <= start[s] |
                    (start_mem_q[s] & !ind_clr);
                trip_mem_q[s] <= trip_q[s] |
                    (trip_mem_q[s] & !ind_clr);
            end
        end
    end

    always_comb
    begin
        for (int s = 0; s < 2; s++)
        begin
            start_show[s] = start[s] |
                (ind_mode[2 * s] & start_mem_q[s]);
            trip_show[s] = trip_q[s] |
                (ind_mode[2 * s + 1] & trip_mem_q[s]);
        end
    end

    assign low_indicator_out.red = trip_show[0];
    assign low_indicator_out.yellow = start_show[0] & !trip_show[0];
    assign high_indicator_out.red = trip_show[1];
    assign high_indicator_out.yellow = start_show[1] & !trip_show[1];

    assign low_stage_start_out = start[0];
    assign high_stage_start_out = start[1];
    assign low_stage_trip_out = trip_q[0];
    assign high_stage_trip_out = trip_q[1];
    assign reclose_start_a_out = start[0];
    assign reclose_start_b_out = start[1];

    // Faulted-phase indication, caught on a trip while display is dark
    assign pf_set = display_blank_in ?
        (((trip_cond[0] & !trip_q[0]) ? over_q[0] : 3'h0) |
        ((trip_cond[1] & !trip_q[1]) ? over_q[1] : 3'h0)) : 3'h0;
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            pf_q <= 3'h0;
        else
            pf_q <= pf_set | (pf_clr ? 3'h0 : pf_q);
    end
    assign phase_fault_out = pf_q;

    // Self-supervision: a fault that persists is permanent
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            alarm_cnt_q <= 32'h0;
            alarm_q <= 1'b0;
            code_q <= 12'h000;
        end
        else if (!alarm_q)
        begin
            if (!internal_fault_in)
                alarm_cnt_q <= 32'h0;
            else if (alarm_cnt_q == ALARM_CYCLES - 1)
            begin
                alarm_q <= 1'b1;
                code_q <= fault_code_in;
            end
            else
                alarm_cnt_q <= alarm_cnt_q + 32'h1;
        end
    end
    assign self_supervision_alarm_out = alarm_q;
    assign supervision_relay_out = alarm_q;
    assign display_fault_out = alarm_q;

    // Display: fault code overrides, else the selected setting
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            disp_q <= 16'h0000;
            led_q <= 6'h00;
        end
        else if (alarm_q)
        begin
            disp_q <= {4'h1, code_q};
            led_q <= 6'h00;
        end
        else
        begin
            led_q <= 6'h00;
            case (display_sel_in)
                3'h0: disp_q <= thr[0];
                3'h1: disp_q <= sg[`SW_CHAR_BIT] ? low_k_q : low_time_q;
                3'h2: disp_q <= high_inf ? 16'hffff : thr[1];
                3'h3: disp_q <= high_time_q;
                3'h4: disp_q <= {8'h00, sg};
                default: disp_q <= 16'h0000;
            endcase
            if (display_sel_in < 3'h5)
                led_q <= 6'(6'h01 << display_sel_in);
        end
    end
    assign display_value_out = disp_q;
    assign knob_led_out = led_q;

    // AHB-Lite slave, zero wait states, always OKAY
    assign addr_ph = hsel_in & hready_in & htrans_in[1];
    always_comb
    begin
        case (haddr_in[7:0])
            `REG_SWITCH: rmux = {16'h0, switch_q};
            `REG_LOW_SET: rmux = {16'h0, low_set_q};
            `REG_LOW_TIME: rmux = {16'h0, low_time_q};
            `REG_LOW_K: rmux = {16'h0, low_k_q};
            `REG_HIGH_SET: rmux = {15'h0, high_set_q};
            `REG_HIGH_TIME: rmux = {16'h0, high_time_q};
            `REG_STATUS: rmux = {20'h0, alarm_q, pf_q, trip_show,
                start_show, trip_q, start};
            `REG_CHECKSUM: rmux = {24'h0, sg};
            default: rmux = 32'h0;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            addr_q <= 8'h00;
            wr_pend_q <= 1'b0;
            rdata_q <= 32'h0;
        end
        else
        begin
            wr_pend_q <= addr_ph & hwrite_in;
            if (addr_ph)
                addr_q <= haddr_in[7:0];
            if (addr_ph && !hwrite_in)
                rdata_q <= rmux;
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            switch_q <= `RST_SWITCH;
            low_set_q <= `RST_LOW_SET;
            low_time_q <= `RST_TIME;
            low_k_q <= `RST_TIME;
            high_set_q <= {1'b0, `RST_HIGH_SET};
            high_time_q <= `RST_TIME;
        end
        else if (wr_pend_q)
        begin
            case (addr_q)
                `REG_SWITCH: switch_q <= hwdata_in[15:0];
                `REG_LOW_SET: low_set_q <= hwdata_in[15:0];
                `REG_LOW_TIME: low_time_q <= hwdata_in[15:0];
                `REG_LOW_K: low_k_q <= hwdata_in[15:0];
                `REG_HIGH_SET: high_set_q <= hwdata_in[16:0];
                `REG_HIGH_TIME: high_time_q <= hwdata_in[15:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            cmd_a_q <= 1'b0;
            cmd_b_q <= 1'b0;
        end
        else
        begin
            cmd_a_q <= wr_pend_q && addr_q == `REG_CMD &&
                hwdata_in[`CMD_RESET_A_BIT];
            cmd_b_q <= wr_pend_q && addr_q == `REG_CMD &&
                hwdata_in[`CMD_RESET_B_BIT];
        end
    end

    assign hrdata_out = rdata_q;
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!nrst_in);

    red_shows_trip_a: assert property (trip_q[0] |->
        low_indicator_out.red && !low_indicator_out.yellow)
        else $error("low trip not shown red");
    manual_hold_a: assert property (ind_mode[0] && start[0] ##1
        !start[0] && !ind_clr |-> low_indicator_out.yellow ||
        low_indicator_out.red)
        else $error("manual start indication lost");
    manual_clear_a: assert property (ind_clr && !start[0] ##1
        !start[0] && !trip_show[0] |-> !low_indicator_out.yellow)
        else $error("manual indication not cleared");
    trip_after_start_a: assert property ($rose(trip_q[1]) |->
        $past(start[1]) && !$past(block[1]))
        else $error("high trip without start");
    block_inhibit_a: assert property (block[0] && !sg[`SW_LATCH_BIT]
        ##1 block[0] |-> !low_stage_trip_out)
        else $error("blocked low stage tripped");
    infinite_off_a: assert property (high_inf |->
        !high_stage_start_out ##1 !high_stage_trip_out)
        else $error("infinite high stage operated");
    alarm_delay_a: assert property ($rose(alarm_q) |->
        $past(internal_fault_in) && supervision_relay_out)
        else $error("alarm without persistent fault");
    phase_clear_a: assert property (pf_clr && pf_set == 3'h0 |=>
        phase_fault_out == 3'h0)
        else $error("phase indication not cleared");
    latch_hold_a: assert property (sg[`SW_LATCH_BIT] && trip_q[0] &&
        !latch_clr |=> trip_q[0])
        else $error("latched trip dropped");
    reclose_start_a: assert property ($rose(reclose_start_a_out) |->
        $past(meas_valid_in))
        else $error("reclose start without measurement");
endmodule : overcurrent_stage_indication

// ---- include/oc_stage_defines.svh ----
// Register map, field positions, setting limits and timing constants
`ifndef OC_STAGE_DEFINES_SVH
`define OC_STAGE_DEFINES_SVH

`define CLK_HZ 10000000
`define TICK_MS 10
`define ALARM_US 10

`define REG_SWITCH 8'h00
`define REG_LOW_SET 8'h04
`define REG_LOW_TIME 8'h08
`define REG_LOW_K 8'h0c
`define REG_HIGH_SET 8'h10
`define REG_HIGH_TIME 8'h14
`define REG_CMD 8'h18
`define REG_STATUS 8'h1c
`define REG_CHECKSUM 8'h20

`define SW_CHAR_BIT 2
`define SW_LATCH_BIT 3
`define SW_HRANGE_BIT 5
`define HIGH_INF_BIT 16
`define CMD_RESET_A_BIT 0
`define CMD_RESET_B_BIT 1

`define RST_SWITCH 16'h0000
`define RST_LOW_SET 16'h0032
`define RST_HIGH_SET 16'h00fa
`define RST_TIME 16'h0005

`define LOW_THR_MIN 16'h0032
`define LOW_THR_MAX 16'h00fa
`define HIGH_THR_MIN_A 16'h00fa
`define HIGH_THR_MAX_A 16'h07d0
`define HIGH_THR_MIN_B 16'h0032
`define HIGH_THR_MAX_B 16'h0190
`define LOW_TIME_MIN 16'h0005
`define HIGH_TIME_MIN 16'h0004
`define TIME_MAX 16'h0064
`define INV_TIME_SCALE 17'h0000a

`endif

// ---- include/oc_stage_pkg.sv ----
// Types shared by the overcurrent indication block and its bench
package oc_stage_pkg;
    typedef struct packed {
        logic [15:0] l3;
        logic [15:0] l2;
        logic [15:0] l1;
    } phase_currents_t;

    typedef struct packed {
        logic yellow;
        logic red;
    } two_colour_t;
endpackage : oc_stage_pkg

// ---- sim/relay_assembly_model.sv ----
// Measurement source standing in for the host relay assembly
`timescale 1ns/10ps
module relay_assembly_model
    import oc_stage_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    // Phase levels requested by the bench
    input wire oc_stage_pkg::phase_currents_t level_in,
    // Measurement stream
    output logic meas_valid_out,
    output oc_stage_pkg::phase_currents_t currents_out
);
    logic [1:0] div_q;

    // One sample every four cycles; data is scrambled between samples
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            div_q <= 2'h0;
            meas_valid_out <= 1'b0;
            currents_out <= '0;
        end
        else
        begin
            div_q <= div_q + 2'h1;
            meas_valid_out <= (div_q == 2'h3);
            currents_out <= (div_q == 2'h3) ? level_in : ~level_in;
        end
    end
endmodule : relay_assembly_model

// ---- sim/overcurrent_stage_indication_test.sv ----
// Self-checking bench for the overcurrent indication block
`timescale 1ns/10ps
`include "oc_stage_defines.svh"
module overcurrent_stage_indication_test;
    import oc_stage_pkg::*;
    logic sys_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    wire logic hready;
    wire logic [31:0] hrdata;
    wire logic meas_valid;
    wire phase_currents_t currents;
    phase_currents_t level = '0;
    logic ext_a = 1'b0;
    logic ext_b = 1'b0;
    logic ext_c = 1'b0;
    logic step_btn = 1'b0;
    logic reset_btn = 1'b0;
    logic blank = 1'b0;
    logic [2:0] disp_sel = 3'h0;
    logic int_fault = 1'b0;
    wire logic low_start, low_trip, high_start, high_trip;
    wire logic rec_a, rec_b, alarm, relay, disp_fault;
    wire two_colour_t low_ind, high_ind;
    wire logic [2:0] phase_fault;
    wire logic [15:0] disp_value;
    wire logic [5:0] knob_led;
    int n_errors = 0;
    int total_checks = 0;
    logic [31:0] rd;

    always #50 sys_clk_in = ~sys_clk_in;

    relay_assembly_model feeder_u (
        .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .level_in(level),
        .meas_valid_out(meas_valid), .currents_out(currents));

    overcurrent_stage_indication #(.TICK_CYCLES(10), .ALARM_CYCLES(4)) dut_u (
        .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
        .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(),
        .meas_valid_in(meas_valid), .currents_in(currents),
        .ext_block_in_a(ext_a), .ext_block_in_b(ext_b),
        .ext_block_in_c(ext_c), .step_btn_in(step_btn),
        .reset_btn_in(reset_btn), .display_blank_in(blank),
        .display_sel_in(disp_sel), .internal_fault_in(int_fault),
        .fault_code_in(12'h123), .low_stage_start_out(low_start),
        .low_stage_trip_out(low_trip), .high_stage_start_out(high_start),
        .high_stage_trip_out(high_trip), .reclose_start_a_out(rec_a),
        .reclose_start_b_out(rec_b), .low_indicator_out(low_ind),
        .high_indicator_out(high_ind), .phase_fault_out(phase_fault),
        .self_supervision_alarm_out(alarm), .supervision_relay_out(relay),
        .display_value_out(disp_value), .display_fault_out(disp_fault),
        .knob_led_out(knob_led));

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    task automatic check_bit(input logic got, input logic exp, input string m);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : check_bit

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp,
        input string m);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: %s got %h", $time, m, got);
        end
    endtask : check_word

    // Address phase held until the slave is ready
    task automatic bus_addr(input logic [7:0] addr, input logic wr);
        hsel <= 1'b1;
        haddr <= {24'h0, addr};
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge sys_clk_in);
        while (hready !== 1'b1)
            @(posedge sys_clk_in);
        htrans <= 2'h0;
        hsel <= 1'b0;
    endtask : bus_addr

    task automatic bus_write(input logic [7:0] addr, input logic [31:0] data);
        bus_addr(addr, 1'b1);
        hwdata <= data;
        @(posedge sys_clk_in);
        while (hready !== 1'b1)
            @(posedge sys_clk_in);
    endtask : bus_write

    task automatic bus_read(input logic [7:0] addr, output logic [31:0] data);
        bus_addr(addr, 1'b0);
        @(posedge sys_clk_in);
        while (hready !== 1'b1)
            @(posedge sys_clk_in);
        data = hrdata;
    endtask : bus_read

    // Waits a bounded time for one output to go high
    task automatic await(input int sel, input int lim);
        int k;
        logic s;
        for (k = 0; k < lim; k++)
        begin
            @(posedge sys_clk_in);
            case (sel)
                0: s = low_start;
                1: s = low_trip;
                2: s = high_start;
                3: s = high_trip;
                default: s = alarm;
            endcase
            if (s === 1'b1)
                break;
        end
    endtask : await

    task automatic press(input logic step, input logic rst);
        step_btn <= step;
        reset_btn <= rst;
        @(posedge sys_clk_in);
        step_btn <= 1'b0;
        reset_btn <= 1'b0;
        repeat (3) @(posedge sys_clk_in);
    endtask : press

    // Overcurrent on L1, trip, then removal of the fault
    task automatic low_fault_cycle();
        level <= '{l3: 16'h0, l2: 16'h0, l1: 16'h00c8};
        await(1, 300);
        check_bit(low_trip, 1'b1, "cycle trip");
        level <= '0;
        repeat (20) @(posedge sys_clk_in);
    endtask : low_fault_cycle

    initial
    begin
        #2_000_000;
        n_errors++;
        report_and_stop();
    end

    initial
    begin : main_seq
        logic [7:0] addrs [5];
        logic [15:0] vals [5];
        int i;
        addrs = '{`REG_SWITCH, `REG_LOW_SET, `REG_HIGH_SET, `REG_LOW_TIME, 8'h40};
        vals = '{`RST_SWITCH, `RST_LOW_SET, `RST_HIGH_SET, `RST_TIME, 16'h0};
        repeat (5) @(posedge sys_clk_in);
        nrst_in <= 1'b1;
        @(posedge sys_clk_in);
        for (i = 0; i < 5; i++)
        begin
            bus_read(addrs[i], rd);
            check_word(rd, {16'h0, vals[i]}, "reset value");
        end
        $display("test reset_values done");
        bus_write(`REG_LOW_SET, 32'h64);
        bus_write(`REG_LOW_TIME, 32'h5);
        repeat (4) @(posedge sys_clk_in);
        check_word({16'h0, disp_value}, 32'h64, "shown setting");
        check_bit($onehot(knob_led), 1'b1, "knob indicator");
        level <= '{l3: 16'h0, l2: 16'h0, l1: 16'h00c8};
        await(0, 20);
        check_bit(low_start, 1'b1, "low start");
        check_bit(rec_a, 1'b1, "reclose start a");
        check_bit(low_trip, 1'b0, "early trip");
        check_word({30'h0, low_ind}, 32'h2, "yellow");
        await(1, 300);
        check_bit(low_trip, 1'b1, "low trip");
        check_word({30'h0, low_ind}, 32'h1, "red");
        check_bit(high_start, 1'b0, "high start idle");
        level <= '0;
        repeat (20) @(posedge sys_clk_in);
        check_bit(low_trip, 1'b0, "self reset trip");
        check_word({30'h0, low_ind}, 32'h0, "self reset ind");
        $display("test definite_time done");
        bus_write(`REG_SWITCH, 32'h0300);
        low_fault_cycle();
        check_bit(low_trip, 1'b0, "trip with lit ind");
        check_word({30'h0, low_ind}, 32'h1, "manual memory");
        press(1'b0, 1'b1);
        check_word({30'h0, low_ind}, 32'h0, "button clear");
        low_fault_cycle();
        bus_write(`REG_CMD, 32'h2);
        repeat (3) @(posedge sys_clk_in);
        check_word({30'h0, low_ind}, 32'h0, "serial clear");
        $display("test manual_reset done");
        bus_write(`REG_SWITCH, 32'h0008);
        low_fault_cycle();
        check_bit(low_trip, 1'b1, "latched trip");
        bus_write(`REG_CMD, 32'h1);
        repeat (3) @(posedge sys_clk_in);
        check_bit(low_trip, 1'b0, "latch cleared");
        $display("test latching done");
        bus_write(`REG_SWITCH, 32'h0004);
        level <= '{l3: 16'h0, l2: 16'h0, l1: 16'h00c8};
        await(0, 20);
        repeat (300) @(posedge sys_clk_in);
        check_bit(low_trip, 1'b0, "inverse early");
        await(1, 400);
        check_bit(low_trip, 1'b1, "inverse trip");
        level <= '0;
        repeat (20) @(posedge sys_clk_in);
        $display("test inverse_time done");
        for (i = 0; i < 2; i++)
        begin
            bus_write(`REG_SWITCH, i == 0 ? 32'h1000 : 32'h4000);
            ext_a <= (i == 0);
            ext_c <= (i == 1);
            level <= '{l3: 16'h00c8, l2: 16'h0, l1: 16'h0};
            await(0, 20);
            check_bit(low_start, 1'b1, "blocked start");
            repeat (150) @(posedge sys_clk_in);
            check_bit(low_trip, 1'b0, "blocked trip");
            ext_a <= 1'b0;
            ext_c <= 1'b0;
            await(1, 300);
            check_bit(low_trip, 1'b1, "unblocked trip");
            level <= '0;
            repeat (20) @(posedge sys_clk_in);
        end
        $display("test blocking done");
        bus_write(`REG_SWITCH, 32'h0);
        bus_write(`REG_HIGH_SET, 32'h1_00fa);
        blank <= 1'b1;
        level <= '{l3: 16'h0, l2: 16'h09c4, l1: 16'h09c4};
        await(1, 300);
        check_bit(high_start, 1'b0, "infinite setting");
        repeat (3) @(posedge sys_clk_in);
        check_word({29'h0, phase_fault}, 32'h3, "faulted phases");
        bus_write(`REG_HIGH_SET, 32'h00fa);
        await(2, 30);
        check_bit(high_start, 1'b1, "high start");
        check_bit(rec_b, 1'b1, "reclose start b");
        await(3, 300);
        check_word({30'h0, high_ind}, 32'h1, "high red");
        level <= '0;
        repeat (20) @(posedge sys_clk_in);
        press(1'b1, 1'b0);
        check_word({29'h0, phase_fault}, 32'h0, "phase clear");
        blank <= 1'b0;
        $display("test high_stage done");
        bus_write(`REG_SWITCH, 32'h00a5);
        disp_sel <= 3'h4;
        repeat (3) @(posedge sys_clk_in);
        check_word({16'h0, disp_value}, 32'ha5, "checksum shown");
        check_word({26'h0, knob_led}, 32'h10, "checksum knob");
        bus_read(`REG_CHECKSUM, rd);
        check_word(rd, 32'ha5, "checksum read");
        $display("test checksum done");
        int_fault <= 1'b1;
        await(4, 20);
        check_bit(alarm, 1'b1, "alarm lit");
        check_bit(relay, 1'b1, "supervision relay");
        check_bit(disp_fault, 1'b1, "fault code shown");
        @(posedge sys_clk_in);
        check_word({16'h0, disp_value}, 32'h1123, "fault code");
        $display("test supervision done");
        report_and_stop();
    end
endmodule : overcurrent_stage_indication_test
